// ### dcp_data_cache.sv
// Data cache policy, copyback buffer, snoop handling and AXI4-Lite control
`timescale 1ns/1ps
module dcp_data_cache #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Integer unit access
   input dcp_pkg::dcp_cpu_req_t cpu_req,
   output logic cpu_ack,
   output logic [31:0] cpu_rdata,
   // External bus, word transfers
   output dcp_pkg::dcp_bus_req_t bus_out,
   input wire logic bus_ack,
   input wire logic [31:0] bus_rdata,
   // Alternate master snoop
   input dcp_pkg::dcp_snoop_t snoop_in,
   output dcp_pkg::dcp_snoop_rsp_t snoop_rsp,
   // AXI4-Lite write
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);
   import dcp_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_PLAN = 3'b001,
      S_WB = 3'b010,
      S_FILL = 3'b011,
      S_SINGLE = 3'b100,
      S_DONE = 3'b101
   } dcp_state_t;

   // Line storage; no instruction cache port exists, so data writes never reach it
   logic [TAG_W-1:0] tag_mem [SETS*WAYS];
   logic [SETS*WAYS-1:0] valid_mem;
   logic [LWORDS-1:0] dirty_mem [SETS*WAYS];
   logic [31:0] data_mem [SETS*WAYS*LWORDS];

   dcp_state_t state, next_state;
   logic [PF_W-1:0] flags, next_flags, plan_flags;
   logic [LW_W-1:0] cnt, next_cnt;
   dcp_bus_req_t next_bus;
   logic xlate_en;
   logic push_pending;
   logic [31:0] push_addr;
   logic [31:0] hit_count, miss_count;
   logic [WAY_W-1:0] rr_ptr;
   // Job held while the bus sequence runs
   logic j_write, j_push, j_update, j_dirty, j_from_cache;
   logic [31:0] j_addr, j_wdata, single_rdata;
   logic [3:0] j_be;
   logic [WAY_W-1:0] j_way;
   logic [LINE_W-1:0] cb_line;
   logic [31:0] cb_data [LWORDS];

   // Tag compare over the four ways of a set
   function automatic logic [WAY_W:0] lookup(input logic [IDX_W-1:0] idx, input logic [TAG_W-1:0] tag);
      logic [WAY_W:0] r;
      r = '0;
      for (int w = 0; w < WAYS; w++)
      begin
         if (valid_mem[{idx, w[WAY_W-1:0]}] && tag_mem[{idx, w[WAY_W-1:0]}] == tag)
            r = {1'b1, w[WAY_W-1:0]};
      end
      return r;
   endfunction

   // Dirty only counts on a valid line
   function automatic logic line_dirty(input logic [IDX_W+WAY_W-1:0] slot);
      return valid_mem[slot] && (|dirty_mem[slot]);
   endfunction

   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
            r[b*8 +: 8] = nw[b*8 +: 8];
      end
      return r;
   endfunction

   // First outstanding bus step, else finish
   function automatic dcp_state_t pick(input logic [PF_W-1:0] f);
      if (f[PF_PRE_WB] || (f[PF_POST_WB] && !f[PF_FILL]))
         return S_WB;
      else if (f[PF_FILL])
         return S_FILL;
      else if (f[PF_SINGLE])
         return S_SINGLE;
      else
         return S_DONE;
   endfunction

   // Address split for both requesters
   logic [IDX_W-1:0] c_idx, s_idx;
   logic [TAG_W-1:0] c_tag;
   logic [LW_W-1:0] s_lw;
   logic [WAY_W:0] c_look, s_look;
   logic [IDX_W+WAY_W-1:0] c_slot, s_slot, v_slot;
   logic snoop_go, j_push_sel, push_go, cpu_go, job_go;
   assign c_idx = j_push_sel ? push_addr[IDX_LSB +: IDX_W] : cpu_req.addr[IDX_LSB +: IDX_W];
   assign c_tag = j_push_sel ? push_addr[TAG_LSB +: TAG_W] : cpu_req.addr[TAG_LSB +: TAG_W];
   assign s_idx = snoop_in.addr[IDX_LSB +: IDX_W];
   assign s_lw = snoop_in.addr[LW_LSB +: LW_W];
   // Procedural so that array updates rerun the compare, not only address changes
   always_comb
   begin
      c_look = lookup(c_idx, c_tag);
      s_look = lookup(s_idx, snoop_in.addr[TAG_LSB +: TAG_W]);
   end
   assign c_slot = {c_idx, c_look[WAY_W-1:0]};
   assign s_slot = {s_idx, s_look[WAY_W-1:0]};

   // Arbitration in idle: snoop first, then push, then integer unit
   logic [1:0] snoop_code;
   logic snoop_active;
   assign snoop_code = {snoop_in.snoop_ctl_hi, snoop_in.snoop_ctl_lo};
   assign snoop_active = (snoop_code == 2'b01) || (snoop_code == 2'b10);
   assign snoop_go = (state == S_IDLE) && snoop_in.valid && !snoop_rsp.done;
   assign j_push_sel = push_pending;
   assign push_go = (state == S_IDLE) && !snoop_in.valid && push_pending;
   assign cpu_go = (state == S_IDLE) && !snoop_in.valid && !push_pending && cpu_req.valid && !cpu_ack;
   assign job_go = push_go || cpu_go;

   // Victim: an invalid way if any, else round robin
   logic [WAY_W-1:0] victim;
   always_comb
   begin
      victim = rr_ptr;
      for (int w = WAYS - 1; w >= 0; w--)
      begin
         if (!valid_mem[{c_idx, w[WAY_W-1:0]}])
            victim = w[WAY_W-1:0];
      end
   end
   assign v_slot = {c_idx, victim};

   // Access policy from mode and class side inputs
   dcp_mode_t eff_mode;
   logic c_nc, c_blk, p_inval, p_update, p_dirty, p_from_cache, p_alloc;
   always_comb
   begin
      eff_mode = xlate_en ? cpu_req.cache_mode_field : CM_WRITETHROUGH;
      c_nc = (eff_mode == CM_NONCACHE) || (eff_mode == CM_NONCACHE_SER) || (cpu_req.cls == AC_LOCKED);
      c_blk = (cpu_req.cls == AC_BLOCK_MOVE);
      plan_flags = '0;
      p_inval = 1'b0;
      p_update = 1'b0;
      p_dirty = 1'b0;
      p_from_cache = 1'b0;
      p_alloc = 1'b0;
      if (push_go)
      begin
         // Explicit push writes out a dirty line and drops it
         p_inval = c_look[WAY_W];
         plan_flags[PF_PRE_WB] = c_look[WAY_W] && line_dirty(c_slot);
      end
      else if (c_look[WAY_W])
      begin
         if (c_nc || (c_blk && cpu_req.write))
         begin
            p_inval = 1'b1;
            plan_flags[PF_PRE_WB] = line_dirty(c_slot);
            plan_flags[PF_SINGLE] = 1'b1;
         end
         else if (!cpu_req.write)
            p_from_cache = 1'b1;
         else if (eff_mode == CM_COPYBACK)
         begin
            p_update = 1'b1;
            p_dirty = 1'b1;
         end
         else
         begin
            p_update = 1'b1;
            plan_flags[PF_SINGLE] = 1'b1;
         end
      end
      else if (c_nc || c_blk || (cpu_req.cls == AC_NO_ALLOC) || (cpu_req.write && eff_mode == CM_WRITETHROUGH))
         plan_flags[PF_SINGLE] = 1'b1;
      else
      begin
         p_alloc = 1'b1;
         plan_flags[PF_FILL] = 1'b1;
         plan_flags[PF_POST_WB] = line_dirty(v_slot);
         p_update = cpu_req.write;
         p_dirty = cpu_req.write;
         p_from_cache = !cpu_req.write;
      end
   end

   // Sequencer next state
   always_comb
   begin
      next_state = state;
      next_flags = flags;
      next_cnt = cnt;
      case (state)
         S_IDLE:
         begin
            if (job_go)
            begin
               next_state = S_PLAN;
               next_flags = plan_flags;
               next_cnt = '0;
            end
         end
         S_PLAN:
            next_state = pick(flags);
         S_WB, S_FILL:
         begin
            if (bus_ack)
            begin
               next_cnt = cnt + LW_W'(1);
               if (cnt == LW_LAST)
               begin
                  if (state == S_FILL)
                     next_flags[PF_FILL] = 1'b0;
                  else if (flags[PF_PRE_WB])
                     next_flags[PF_PRE_WB] = 1'b0;
                  else
                     next_flags[PF_POST_WB] = 1'b0;
                  next_state = pick(next_flags);
               end
            end
         end
         S_SINGLE:
         begin
            if (bus_ack)
            begin
               next_flags[PF_SINGLE] = 1'b0;
               next_state = pick(next_flags);
            end
         end
         S_DONE:
            next_state = S_IDLE;
         default:
            next_state = S_IDLE;
      endcase
   end

   // Bus word for the coming cycle; line transfers walk long words 0..3
   always_comb
   begin
      next_bus = '0;
      case (next_state)
         S_WB:
         begin
            next_bus.req = 1'b1;
            next_bus.write = 1'b1;
            next_bus.addr = {cb_line, next_cnt, 2'b00};
            next_bus.wdata = cb_data[next_cnt];
            next_bus.be = 4'hF;
         end
         S_FILL:
         begin
            next_bus.req = 1'b1;
            next_bus.addr = {j_addr[31:IDX_LSB], next_cnt, 2'b00};
            next_bus.be = 4'hF;
         end
         S_SINGLE:
         begin
            next_bus.req = 1'b1;
            next_bus.write = j_write;
            next_bus.addr = j_addr;
            next_bus.wdata = j_wdata;
            next_bus.be = j_write ? j_be : 4'hF;
         end
         default:
            next_bus = '0;
      endcase
   end

   // Sequencer registers and bus request
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state <= S_IDLE;
         flags <= '0;
         cnt <= '0;
         bus_out <= '0;
      end
      else
      begin
         state <= next_state;
         flags <= next_flags;
         cnt <= next_cnt;
         bus_out <= next_bus;
      end
   end

   // Job capture and copyback buffer load at acceptance
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         j_write <= 1'b0;
         j_push <= 1'b0;
         j_update <= 1'b0;
         j_dirty <= 1'b0;
         j_from_cache <= 1'b0;
         j_addr <= '0;
         j_wdata <= '0;
         j_be <= '0;
         j_way <= '0;
         cb_line <= '0;
         rr_ptr <= '0;
         single_rdata <= '0;
      end
      else
      begin
         if (job_go)
         begin
            j_write <= cpu_go && cpu_req.write;
            j_push <= push_go;
            j_update <= p_update;
            j_dirty <= p_dirty;
            j_from_cache <= p_from_cache;
            j_addr <= push_go ? push_addr : cpu_req.addr;
            j_wdata <= cpu_req.wdata;
            j_be <= cpu_req.be;
            j_way <= p_alloc ? victim : c_look[WAY_W-1:0];
            // Victim line leaves through the buffer, so the fill may overwrite it
            cb_line <= p_alloc ? {tag_mem[v_slot], c_idx} : {c_tag, c_idx};
            for (int i = 0; i < LWORDS; i++)
               cb_data[i] <= data_mem[{(p_alloc ? v_slot : c_slot), i[LW_W-1:0]}];
            if (p_alloc && valid_mem[v_slot])
               rr_ptr <= rr_ptr + WAY_W'(1);
         end
         if (state == S_SINGLE && bus_ack)
            single_rdata <= bus_rdata;
      end
   end

   // Array updates: snoop, acceptance invalidate, fill, completion merge
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         valid_mem <= '0;
      else
      begin
         if (snoop_go && snoop_active && s_look[WAY_W])
         begin
            if (snoop_code == 2'b10)
            begin
               valid_mem[s_slot] <= 1'b0;
               dirty_mem[s_slot] <= '0;
            end
            else if (snoop_in.write)
            begin
               // Sunk data is newer than memory, so the long word turns dirty
               data_mem[{s_slot, s_lw}] <= merge_bytes(data_mem[{s_slot, s_lw}], snoop_in.wdata, snoop_in.be);
               dirty_mem[s_slot][s_lw] <= 1'b1;
            end
         end
         if (job_go && p_inval)
         begin
            valid_mem[c_slot] <= 1'b0;
            dirty_mem[c_slot] <= '0;
         end
         if (state == S_FILL && bus_ack)
         begin
            data_mem[{j_addr[IDX_LSB +: IDX_W], j_way, cnt}] <= bus_rdata;
            if (cnt == LW_LAST)
            begin
               tag_mem[{j_addr[IDX_LSB +: IDX_W], j_way}] <= j_addr[TAG_LSB +: TAG_W];
               valid_mem[{j_addr[IDX_LSB +: IDX_W], j_way}] <= 1'b1;
               dirty_mem[{j_addr[IDX_LSB +: IDX_W], j_way}] <= '0;
            end
         end
         if (state == S_DONE && j_update)
         begin
            data_mem[{j_addr[IDX_LSB +: IDX_W], j_way, j_addr[LW_LSB +: LW_W]}] <=
               merge_bytes(data_mem[{j_addr[IDX_LSB +: IDX_W], j_way, j_addr[LW_LSB +: LW_W]}], j_wdata, j_be);
            if (j_dirty)
               dirty_mem[{j_addr[IDX_LSB +: IDX_W], j_way}][j_addr[LW_LSB +: LW_W]] <= 1'b1;
         end
      end
   end

   // Integer unit answer
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         cpu_ack <= 1'b0;
         cpu_rdata <= '0;
      end
      else
      begin
         cpu_ack <= (state == S_DONE) && !j_push;
         if (state == S_DONE && !j_push)
            cpu_rdata <= j_from_cache ? data_mem[{j_addr[IDX_LSB +: IDX_W], j_way, j_addr[LW_LSB +: LW_W]}] :
               single_rdata;
      end
   end

   // Snoop answer; intervention only on dirty data, memory answers clean lines
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         snoop_rsp <= '0;
      else
      begin
         snoop_rsp.done <= snoop_go;
         snoop_rsp.hit <= snoop_go && snoop_active && s_look[WAY_W];
         snoop_rsp.supply <= snoop_go && snoop_active && !snoop_in.write && s_look[WAY_W] && line_dirty(s_slot);
         snoop_rsp.rdata <= data_mem[{s_slot, s_lw}];
      end
   end

   // Hit and miss counters for software
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         hit_count <= '0;
         miss_count <= '0;
      end
      else if (cpu_go)
      begin
         if (c_look[WAY_W])
            hit_count <= hit_count + 32'h1;
         else
            miss_count <= miss_count + 32'h1;
      end
   end

   // AXI4-Lite write path; address and data taken together
   logic wr_take;
   assign wr_take = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         xlate_en <= CTRL_XLATE_RESET;
         push_pending <= 1'b0;
         push_addr <= '0;
      end
      else
      begin
         s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         // A new push request wins over the clear of the old one
         if (push_go)
            push_pending <= 1'b0;
         if (wr_take)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OKAY;
            case (8'(s_axi_awaddr))
               REG_CTRL:
               begin
                  if (s_axi_wstrb[0])
                     xlate_en <= s_axi_wdata[CTRL_XLATE_BIT];
               end
               REG_PUSH:
               begin
                  push_addr <= s_axi_wdata;
                  push_pending <= 1'b1;
               end
               REG_STATUS, REG_HITS, REG_MISSES:
                  s_axi_bresp <= RESP_OKAY;
               default:
                  s_axi_bresp <= RESP_SLVERR;
            endcase
         end
      end
   end

   // AXI4-Lite read path
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         if (s_axi_arready && s_axi_arvalid)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
            case (8'(s_axi_araddr))
               REG_CTRL:
                  s_axi_rdata[CTRL_XLATE_BIT] <= xlate_en;
               REG_PUSH:
                  s_axi_rdata <= push_addr;
               REG_STATUS:
               begin
                  s_axi_rdata[ST_BUSY_BIT] <= (state != S_IDLE);
                  s_axi_rdata[ST_PUSH_BIT] <= push_pending;
                  s_axi_rdata[ST_STATE_LSB +: 3] <= state;
               end
               REG_HITS:
                  s_axi_rdata <= hit_count;
               REG_MISSES:
                  s_axi_rdata <= miss_count;
               default:
                  s_axi_rresp <= RESP_SLVERR;
            endcase
         end
      end
   end
endmodule // dcp_data_cache

// ### dcp_pkg.sv
// Constants, types and carriers shared by the data cache policy and snoop block
package dcp_pkg;
   // Geometry
   localparam int SETS = 64;
   localparam int WAYS = 4;
   localparam int LWORDS = 4;
   localparam int IDX_W = 6;
   localparam int WAY_W = 2;
   localparam int LW_W = 2;
   localparam int TAG_W = 22;
   localparam int LINE_W = TAG_W + IDX_W;
   localparam int LW_LSB = 2;
   localparam int IDX_LSB = 4;
   localparam int TAG_LSB = 10;
   localparam logic [LW_W-1:0] LW_LAST = 2'h3;
   // Plan flag positions, taken in this order
   localparam int PF_PRE_WB = 0;
   localparam int PF_FILL = 1;
   localparam int PF_POST_WB = 2;
   localparam int PF_SINGLE = 3;
   localparam int PF_W = 4;
   // Register map, byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_PUSH = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_HITS = 8'h0C;
   localparam logic [7:0] REG_MISSES = 8'h10;
   localparam int CTRL_XLATE_BIT = 0;
   localparam logic CTRL_XLATE_RESET = 1'b0;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_PUSH_BIT = 1;
   localparam int ST_STATE_LSB = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Caching mode carried with every access
   typedef enum logic [1:0] {
      CM_WRITETHROUGH = 2'b00,
      CM_COPYBACK = 2'b01,
      CM_NONCACHE_SER = 2'b10,
      CM_NONCACHE = 2'b11
   } dcp_mode_t;

   // Access class carried with every access
   typedef enum logic [1:0] {
      AC_NORMAL = 2'b00,
      AC_LOCKED = 2'b01,
      AC_NO_ALLOC = 2'b10,
      AC_BLOCK_MOVE = 2'b11
   } dcp_class_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
      dcp_mode_t cache_mode_field;
      dcp_class_t cls;
   } dcp_cpu_req_t;

   typedef struct packed {
      logic req;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } dcp_bus_req_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic snoop_ctl_hi;
      logic snoop_ctl_lo;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } dcp_snoop_t;

   typedef struct packed {
      logic done;
      logic hit;
      logic supply;
      logic [31:0] rdata;
   } dcp_snoop_rsp_t;
endpackage

// ### dcp_mem_model.sv
// Memory controller model answering the cache's word transfers
`timescale 1ns/1ps
module dcp_mem_model (
   // Clock and pacing
   input wire logic sys_clk,
   input wire logic slow,
   // Bus side
   input dcp_pkg::dcp_bus_req_t bus_out,
   output logic bus_ack = 1'b0,
   output logic [31:0] bus_rdata = 32'h0,
   // Snooped handover of dirty data
   input dcp_pkg::dcp_snoop_t snoop_in,
   input dcp_pkg::dcp_snoop_rsp_t snoop_rsp
);
   import dcp_pkg::*;
   logic [31:0] mem [logic [31:0]];
   logic tgl = 1'b0;
   // Whole words only; data lines scramble outside the ack cycle
   always @(posedge sys_clk)
   begin
      // Dirty data passed with mark invalid is captured by memory
      if (snoop_rsp.supply && snoop_in.snoop_ctl_hi && !snoop_in.snoop_ctl_lo)
         mem[snoop_in.addr] = snoop_rsp.rdata;
      tgl <= ~tgl;
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (bus_out.req && !bus_ack && (!slow || tgl))
      begin
         bus_ack <= 1'b1;
         if (bus_out.write)
            mem[bus_out.addr] = bus_out.wdata;
         else
            bus_rdata <= mem.exists(bus_out.addr) ? mem[bus_out.addr] : {bus_out.addr[15:0], 16'h5A5A};
      end
   end
endmodule // dcp_mem_model

// ### dcp_chk_sva.sv
// Port assertions for the data cache policy block
`timescale 1ns/1ps
module dcp_chk (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Watched ports
   input dcp_pkg::dcp_cpu_req_t cpu_req,
   input wire logic cpu_ack,
   input dcp_pkg::dcp_bus_req_t bus_out,
   input wire logic bus_ack,
   input dcp_pkg::dcp_snoop_t snoop_in,
   input dcp_pkg::dcp_snoop_rsp_t snoop_rsp
);
   import dcp_pkg::*;
   logic wrote;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Bus write seen within the current access
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || cpu_ack)
         wrote <= 1'b0;
      else if (bus_out.req && bus_out.write && bus_ack)
         wrote <= 1'b1;
   end
   a_ack_pulse: assert property (cpu_ack |=> !cpu_ack)
      else $error("cpu ack too long");
   a_wt_write_out: assert property (cpu_ack && cpu_req.valid && cpu_req.write
      && cpu_req.cache_mode_field == CM_WRITETHROUGH |-> wrote) else $error("write did not reach memory");
   a_nc_read_single: assert property (bus_out.req && !bus_out.write && cpu_req.valid
      && (cpu_req.cache_mode_field[1] || cpu_req.cls == AC_LOCKED) |-> bus_out.addr[31:2] == cpu_req.addr[31:2])
      else $error("noncachable read fetched other words");
   a_bus_hold: assert property (bus_out.req && !bus_ack |=> bus_out.req && $stable(bus_out))
      else $error("bus request changed before ack");
   a_snoop_pulse: assert property (snoop_rsp.done |=> !snoop_rsp.done)
      else $error("snoop done too long");
   a_snoop_cause: assert property (snoop_rsp.done |-> $past(snoop_in.valid))
      else $error("snoop done without request");
   a_inhibit_code: assert property (snoop_rsp.done && snoop_in.snoop_ctl_hi == snoop_in.snoop_ctl_lo
      |-> !snoop_rsp.hit && !snoop_rsp.supply) else $error("inhibited snoop acted");
   a_supply_read: assert property (snoop_rsp.supply |-> snoop_rsp.done && snoop_rsp.hit && !snoop_in.write)
      else $error("supply outside read hit");
endmodule // dcp_chk

// ### tb_top.sv
// Self-checking bench for the data cache policy block
`timescale 1ns/1ps
module tb_top;
   import dcp_pkg::*;
   typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; dcp_mode_t m; dcp_class_t c;} dcp_row_t;
   logic sys_clk = 1'b0, rst_n = 1'b0, slow = 1'b0, cpu_ack, bus_ack;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] cpu_rdata, bus_rdata, s_axi_rdata, s_axi_wdata = 32'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   dcp_cpu_req_t cpu_req = '0;
   dcp_bus_req_t bus_out;
   dcp_snoop_t snoop_in = '0;
   dcp_snoop_rsp_t snoop_rsp;
   int err_count = 0, total_checks = 0, cycles = 0, nwr = 0;
   // Reads carry expected data, writes their data; translation is off here
   dcp_row_t rows [8] = '{'{1'b0, 32'h1000, 32'h1000_5A5A, CM_WRITETHROUGH, AC_NORMAL},
      '{1'b1, 32'h1000, 32'h1111_1111, CM_WRITETHROUGH, AC_NORMAL}, '{1'b0, 32'h1000, 32'h1111_1111, CM_COPYBACK, AC_NORMAL},
      '{1'b1, 32'h2000, 32'h2222_2222, CM_WRITETHROUGH, AC_NORMAL}, '{1'b0, 32'h1000, 32'h1111_1111, CM_COPYBACK, AC_LOCKED},
      '{1'b0, 32'h1000, 32'h1111_1111, CM_COPYBACK, AC_NORMAL}, '{1'b0, 32'h3004, 32'h3004_5A5A, CM_COPYBACK, AC_NO_ALLOC},
      '{1'b0, 32'h3004, 32'h3004_5A5A, CM_COPYBACK, AC_BLOCK_MOVE}};
   dcp_data_cache u_dut (.*);
   dcp_mem_model u_mem (.*);
   always #2 sys_clk = ~sys_clk;
   // Watchdog and count of bus writes taken
   always @(posedge sys_clk)
   begin
      cycles++;
      if (bus_out.req && bus_out.write && bus_ack)
         nwr++;
      if (cycles == 20000)
      begin
         err_count++;
         close_out();
      end
   end
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic cpu(input dcp_row_t r);
      @(posedge sys_clk);
      cpu_req <= '{1'b1, r.w, r.a, r.d, 4'hF, r.m, r.c};
      do @(posedge sys_clk); while (cpu_ack !== 1'b1);
      cpu_req.valid <= 1'b0;
      if (!r.w)
         check("cpu_rdata", cpu_rdata, r.d);
   endtask
   task automatic snp(input logic h, input logic l, input logic [1:0] hs);
      @(posedge sys_clk);
      snoop_in <= '{1'b1, 1'b0, h, l, 32'h4008, 32'h0, 4'hF};
      do @(posedge sys_clk); while (snoop_rsp.done !== 1'b1);
      snoop_in.valid <= 1'b0;
      check("snoop_hit_supply", {30'h0, snoop_rsp.hit, snoop_rsp.supply}, {30'h0, hs});
      if (hs[0])
         check("snoop_rdata", snoop_rsp.rdata, 32'h4444_4444);
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_bready <= 1'b1;
      do @(posedge sys_clk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check("axi_bresp", {30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] rs);
      @(posedge sys_clk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check("axi_rdata", s_axi_rdata, e);
      check("axi_rresp", {30'h0, s_axi_rresp}, {30'h0, rs});
   endtask
   // Table first, then translation on, copyback, snoop codes and a dirty push
   initial
   begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      check("idle_out", {31'h0, cpu_ack | bus_out.req}, 32'h0);
      foreach (rows[i]) cpu(rows[i]);
      axr(REG_CTRL, 32'h0, RESP_OKAY);
      axw(REG_CTRL, 32'h1);
      axr(REG_CTRL, 32'h1, RESP_OKAY);
      axr(8'hFC, 32'h0, RESP_SLVERR);
      slow <= 1'b1;
      cpu('{1'b1, 32'h4008, 32'h4444_4444, CM_COPYBACK, AC_NORMAL});
      cpu('{1'b1, 32'h4008, 32'h4444_4444, CM_COPYBACK, AC_NORMAL});
      cpu('{1'b0, 32'h4008, 32'h4444_4444, CM_COPYBACK, AC_NORMAL});
      check("bus_writes", 32'(nwr), 32'h2);
      snp(1'b0, 1'b0, 2'b00);
      snp(1'b1, 1'b1, 2'b00);
      snp(1'b0, 1'b1, 2'b11);
      snp(1'b1, 1'b0, 2'b11);
      snp(1'b0, 1'b1, 2'b00);
      cpu('{1'b1, 32'h5000, 32'h5555_5555, CM_COPYBACK, AC_NORMAL});
      cpu('{1'b0, 32'h5000, 32'h5555_5555, CM_NONCACHE, AC_NORMAL});
      check("bus_writes", 32'(nwr), 32'h6);
      cpu('{1'b0, 32'h4008, 32'h4444_4444, CM_NONCACHE_SER, AC_NORMAL});
      cpu('{1'b0, 32'h4008, 32'h4444_4444, CM_NONCACHE, AC_NORMAL});
      cpu('{1'b1, 32'h8000, 32'h8888_8888, CM_COPYBACK, AC_NORMAL});
      // Fill the set; the last miss evicts the dirty line
      for (int a = 9; a < 13; a++)
         cpu('{1'b0, {16'h0, 4'(a), 12'h000}, {4'(a), 12'h000, 16'h5A5A}, CM_COPYBACK, AC_NORMAL});
      cpu('{1'b0, 32'h8000, 32'h8888_8888, CM_NONCACHE, AC_NORMAL});
      check("bus_writes", 32'(nwr), 32'hA);
      cpu('{1'b1, 32'h6000, 32'h6666_6666, CM_COPYBACK, AC_NORMAL});
      axw(REG_PUSH, 32'h6000);
      cpu('{1'b0, 32'h6000, 32'h6666_6666, CM_NONCACHE, AC_NORMAL});
      check("bus_writes", 32'(nwr), 32'hE);
      axr(REG_PUSH, 32'h6000, RESP_OKAY);
      axr(REG_STATUS, 32'h0, RESP_OKAY);
      axr(REG_HITS, 32'h6, RESP_OKAY);
      axr(REG_MISSES, 32'h11, RESP_OKAY);
      close_out();
   end
endmodule // tb_top
bind dcp_data_cache dcp_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_ack(cpu_ack),
   .bus_out(bus_out), .bus_ack(bus_ack), .snoop_in(snoop_in), .snoop_rsp(snoop_rsp));
